// file: hw/xsie_pkg.sv
// constants, encodings and state type for the extended instruction executor
// assumes a core with four clock phases per instruction cycle
package xsie_pkg;

  // phase numbering inside one instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // widths
  localparam int ADDR_W = 12;
  localparam int PC_W   = 21;
  localparam int PCU_W  = 5;

  // opcode patterns
  localparam logic [7:0]  OP_ADD_PTR_HI  = 8'he8;
  localparam logic [1:0]  PTR_SEL_FRAME  = 2'h3;
  localparam logic [1:0]  FRAME_PTR_IDX  = 2'h2;
  localparam logic [15:0] OP_CALL_WORKING_REGISTER   = 16'h0014;
  localparam logic [8:0]  OP_MOVE_IDX_HI = 9'h1d6;
  localparam logic [15:0] OP_NOP_WORD    = 16'h0000;

  // values after reset and fixed values
  localparam logic [11:0] PTR_RST   = 12'h000;
  localparam logic [7:0]  ZERO_BYTE = 8'h00;
  localparam logic [20:0] PC_STEP   = 21'h000002;

  // indirect-access register windows (five registers from each base)
  localparam logic [11:0] IND_BASE0 = 12'hfeb;
  localparam logic [11:0] IND_BASE1 = 12'hfe3;
  localparam logic [11:0] IND_BASE2 = 12'hfdb;
  localparam logic [11:0] IND_SPAN  = 12'h005;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_NOP  = 2'b01,
    ST_MOV2 = 2'b10
  } xsie_state_e;

endpackage

// file: hw/xsie_src_addr.sv
// source address of the indexed move: frame pointer plus offset
// assumes inputs come from registers in the same clock domain
`timescale 1ns/10ps
module xsie_src_addr
  import xsie_pkg::*;
(
  // operands
  input  wire logic [11:0] frame_ptr,
  input  wire logic [6:0]  offset,
  // result
  output wire logic [11:0] src_addr,
  output wire logic        src_is_ind
);

  function automatic logic in_win(input logic [11:0] a,
                                  input logic [11:0] base);
    in_win = (a >= base) && (a < base + IND_SPAN);
  endfunction

  // wraps inside the 4 kB space, no bank involved
  assign src_addr   = frame_ptr + {5'h00, offset};
  assign src_is_ind = in_win(src_addr, IND_BASE0) ||
                      in_win(src_addr, IND_BASE1) ||
                      in_win(src_addr, IND_BASE2);

endmodule // xsie_src_addr

// file: hw/xsie_exec.sv
// executor for four extended instructions: pointer add, frame add and
// return, call through working register, indexed move to file
// assumes fetch presents a word during phase Q1 and memory read data
// is valid in the cycle of the read strobe
`timescale 1ns/10ps

// Function
// - add 6-bit literal to selected pointer
// - frame pointer add, then return from stack
// - frame add-return second cycle is no operation
// - selector 11 means frame add-return only
// - register call pushes address plus two
// - register call: working register to low byte
// - register call: latches to high, upper bytes
// - register call second cycle is no operation
// - no flags, working or bank register touched
// - move source: frame pointer plus 7-bit offset
// - move destination: 12-bit literal, second word
// - addresses span whole 4 kB space
// - indirect source address reads as zero
// - decoding needs extended set enable bit
module xsie_exec
  import xsie_pkg::*;
(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  // configuration pin
  input  wire logic        EXTENDED_SET_ENABLE_BIT,
  // fetch stage
  input  wire logic [15:0] INSTR_WORD,
  input  wire logic        INSTR_VALID,
  output      logic        Q1_STROBE,
  output      logic        NOP_CYCLE,
  // core registers read
  input  wire logic [20:0] PC_IN,
  input  wire logic [7:0]  WORKING_REGISTER,
  input  wire logic [7:0]  PC_HIGH_LATCH,
  input  wire logic [7:0]  PC_UPPER_LATCH,
  input  wire logic [20:0] RETURN_STACK_TOP,
  // program counter and return stack
  output      logic        PC_LOAD,
  output      logic [20:0] PC_LOAD_VAL,
  output      logic        STACK_PUSH,
  output      logic [20:0] STACK_PUSH_VAL,
  output      logic        STACK_POP,
  // data memory
  output      logic        DMEM_RD,
  output      logic        DMEM_WR,
  output      logic [11:0] DMEM_ADDR,
  output      logic [7:0]  DMEM_WDATA,
  input  wire logic [7:0]  DMEM_RDATA,
  // indirect pointers
  output      logic [11:0] PTR0,
  output      logic [11:0] PTR1,
  output      logic [11:0] PTR2
);

  logic        rst_s1_r;
  logic        rst_n;
  logic        ext_s1_r;
  logic        ext_s2_r;
  logic        ext_lat_r;
  logic [1:0]  phase_r;
  logic [1:0]  phase_nxt;
  xsie_state_e state_r;
  xsie_state_e state_nxt;
  logic [15:0] ir_r;
  logic [5:0]  lit_r;
  logic [6:0]  z_r;
  logic [7:0]  working_register_r;
  logic [11:0] sum_r;
  logic [11:0] src_addr_r;
  logic        src_ind_r;
  logic [7:0]  src_data_r;
  logic [11:0] ptr_r [0:2];
  logic [11:0] src_addr;
  logic        src_is_ind;

  // reset release through two flops
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // configuration pin is asynchronous to the core
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
    end else begin
      ext_s1_r <= EXTENDED_SET_ENABLE_BIT;
      ext_s2_r <= ext_s1_r;
    end
  end

  function automatic logic is_add_ptr(input logic [15:0] w);
    is_add_ptr = (w[15:8] == OP_ADD_PTR_HI) && (w[7:6] != PTR_SEL_FRAME);
  endfunction

  function automatic logic is_add_ret(input logic [15:0] w);
    is_add_ret = (w[15:8] == OP_ADD_PTR_HI) && (w[7:6] == PTR_SEL_FRAME);
  endfunction

  // phases and decode
  wire in_run  = (state_r == ST_RUN);
  wire in_mov2 = (state_r == ST_MOV2);
  wire ph_q1   = (phase_r == PH_Q1);
  wire ph_q2   = (phase_r == PH_Q2);
  wire ph_q3   = (phase_r == PH_Q3);
  wire ph_q4   = (phase_r == PH_Q4);
  wire dec_on  = in_run && ext_lat_r;
  wire dec_add_ptr = dec_on && is_add_ptr(ir_r);
  wire dec_add_ret = dec_on && is_add_ret(ir_r);
  wire dec_call    = dec_on && (ir_r == OP_CALL_WORKING_REGISTER);
  wire dec_move    = dec_on && (ir_r[15:7] == OP_MOVE_IDX_HI);
  wire any_dec     = dec_add_ptr || dec_add_ret || dec_call || dec_move;
  wire do_ptr_add  = dec_add_ptr || dec_add_ret;
  // selector 11 is folded onto the frame pointer, never a fourth one
  wire [1:0]  ptr_sel = dec_add_ret ? FRAME_PTR_IDX : ir_r[7:6];
  wire [11:0] sel_ptr = (ptr_sel == 2'h0) ? ptr_r[0] :
                        (ptr_sel == 2'h1) ? ptr_r[1] : ptr_r[2];
  wire [20:0] call_target = {PC_UPPER_LATCH[PCU_W-1:0], PC_HIGH_LATCH,
                             working_register_r};

  assign phase_nxt = phase_r + 2'h1;

  always_comb begin
    state_nxt = state_r;
    if (ph_q4) begin
      case (state_r)
        ST_RUN: begin
          if (dec_add_ret || dec_call)
            state_nxt = ST_NOP;
          else if (dec_move)
            state_nxt = ST_MOV2;
          else
            state_nxt = ST_RUN;
        end
        ST_NOP:  state_nxt = ST_RUN;
        ST_MOV2: state_nxt = ST_RUN;
        default: state_nxt = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      phase_r   <= PH_Q1;
      state_r   <= ST_RUN;
      Q1_STROBE <= 1'b0;
      NOP_CYCLE <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      state_r   <= state_nxt;
      Q1_STROBE <= (phase_nxt == PH_Q1);
      NOP_CYCLE <= (state_nxt == ST_NOP);
    end
  end

  // Q1: take the word; non-valid words are treated as no operation
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ir_r      <= OP_NOP_WORD;
      ext_lat_r <= 1'b0;
    end else if (ph_q1 && !(state_r == ST_NOP)) begin
      ir_r      <= INSTR_VALID ? INSTR_WORD : OP_NOP_WORD;
      ext_lat_r <= ext_s2_r;
    end
  end

  // Q2 read operands, Q3 compute; frozen in nop and second move cycle
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      lit_r      <= 6'h00;
      z_r        <= 7'h00;
      working_register_r     <= ZERO_BYTE;
      sum_r      <= PTR_RST;
      src_addr_r <= PTR_RST;
      src_ind_r  <= 1'b0;
    end else if (ph_q2 && in_run) begin
      lit_r  <= ir_r[5:0];
      z_r    <= ir_r[6:0];
      working_register_r <= WORKING_REGISTER;
    end else if (ph_q3 && in_run) begin
      sum_r      <= sel_ptr + {6'h00, lit_r};
      src_addr_r <= src_addr;
      src_ind_r  <= src_is_ind;
    end
  end

  xsie_src_addr u_src (
    .frame_ptr  (ptr_r[FRAME_PTR_IDX]),
    .offset     (z_r),
    .src_addr   (src_addr),
    .src_is_ind (src_is_ind)
  );

  // Q4: pointer write-back; status flags have no path out of here
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ptr
      always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n)
          ptr_r[gi] <= PTR_RST;
        else if (ph_q4 && do_ptr_add && ptr_sel == 2'(gi))
          ptr_r[gi] <= sum_r;
      end
    end
  endgenerate

  assign PTR0 = ptr_r[0];
  assign PTR1 = ptr_r[1];
  assign PTR2 = ptr_r[2];

  // program counter and return stack strobes
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PC_LOAD        <= 1'b0;
      PC_LOAD_VAL    <= 21'h000000;
      STACK_PUSH     <= 1'b0;
      STACK_PUSH_VAL <= 21'h000000;
      STACK_POP      <= 1'b0;
    end else begin
      PC_LOAD    <= ph_q4 && (dec_add_ret || dec_call);
      STACK_POP  <= ph_q4 && dec_add_ret;
      STACK_PUSH <= ph_q3 && dec_call;
      if (ph_q3 && dec_call)
        STACK_PUSH_VAL <= PC_IN + PC_STEP;
      if (ph_q4 && dec_add_ret)
        PC_LOAD_VAL <= RETURN_STACK_TOP;
      else if (ph_q4 && dec_call)
        PC_LOAD_VAL <= call_target;
    end
  end

  // data memory: read ends cycle one, write ends cycle two
  // a destination naming pc or stack-top bytes is not guarded
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      DMEM_RD    <= 1'b0;
      DMEM_WR    <= 1'b0;
      DMEM_ADDR  <= PTR_RST;
      DMEM_WDATA <= ZERO_BYTE;
      src_data_r <= ZERO_BYTE;
    end else begin
      // no bus read for an indirect source, so its side effects never fire
      DMEM_RD <= ph_q4 && dec_move && !src_ind_r;
      DMEM_WR <= ph_q4 && in_mov2;
      if (ph_q4 && dec_move)
        DMEM_ADDR <= src_addr_r;
      else if (ph_q4 && in_mov2)
        DMEM_ADDR <= ir_r[11:0];
      if (ph_q4 && in_mov2)
        DMEM_WDATA <= src_data_r;
      if (ph_q1 && in_mov2)
        src_data_r <= src_ind_r ? ZERO_BYTE : DMEM_RDATA;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n);

  sequence s_nop_cycle;
    NOP_CYCLE [*4];
  endsequence

  sequence s_call_issue;
    ph_q3 && dec_call ##1 STACK_PUSH;
  endsequence

  chk_ptr_add_sum: assert property (
    (ph_q4 && dec_add_ptr) |=> (sel_ptr == $past(sel_ptr) + {6'h00, lit_r}))
    else $error("pointer add result wrong");

  chk_frame_return: assert property (
    (ph_q4 && dec_add_ret) |=>
      (PC_LOAD && STACK_POP && PC_LOAD_VAL == $past(RETURN_STACK_TOP)))
    else $error("frame add did not return");

  chk_ret_nop_cycle: assert property (
    (ph_q4 && dec_add_ret) |=> s_nop_cycle ##1 !NOP_CYCLE)
    else $error("return second cycle not a nop");

  chk_frame_only: assert property (
    (ph_q4 && dec_add_ret) |=> ($stable(ptr_r[0]) && $stable(ptr_r[1])))
    else $error("frame add touched other pointer");

  chk_call_push_val: assert property (
    (ph_q3 && dec_call) |=>
      (STACK_PUSH && STACK_PUSH_VAL == $past(PC_IN) + PC_STEP))
    else $error("call pushed wrong address");

  chk_call_target: assert property (
    s_call_issue ##0 (ph_q4 && dec_call) |=>
      (PC_LOAD && PC_LOAD_VAL == {$past(PC_UPPER_LATCH[PCU_W-1:0]),
                                  $past(PC_HIGH_LATCH), working_register_r}))
    else $error("call target wrong");

  chk_call_nop_cycle: assert property (
    (ph_q4 && dec_call) |=> s_nop_cycle ##1 (!NOP_CYCLE && !PC_LOAD))
    else $error("call second cycle not a nop");

  chk_move_src: assert property (
    (ph_q3 && dec_move) |=>
      (src_addr_r == $past(ptr_r[FRAME_PTR_IDX]) + {5'h00, $past(z_r)}))
    else $error("move source address wrong");

  chk_move_dst: assert property (
    (ph_q4 && in_mov2) |=> (DMEM_WR && DMEM_ADDR == $past(ir_r[11:0])))
    else $error("move destination write wrong");

  chk_ind_zero: assert property (
    (ph_q4 && in_mov2 && src_ind_r) |=> (DMEM_WDATA == ZERO_BYTE))
    else $error("indirect source not zero");

  chk_ext_gate: assert property (
    (ph_q1 && in_run && !ext_s2_r) |=> !any_dec [*3])
    else $error("decoded with extended set off");

endmodule // xsie_exec

// file: tb/xsie_far_model.sv
// far-side model: data memory and return stack of the core
// assumes registered one-cycle strobes from the executor, one clock
`timescale 1ns/10ps
module xsie_far_model (
  // clock
  input  wire logic        clk,
  // data memory
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wdata,
  output      logic [7:0]  rdata,
  // return stack
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic [20:0] push_val,
  output      logic [20:0] top
);
  logic [7:0]  mem [4096];
  logic [20:0] stk [8];
  logic [2:0]  sp;
  logic [7:0]  last;
  initial begin
    sp = 3'h0;
    last = 8'h00;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ i[11:4];
    end
    for (int i = 0; i < 8; i++) begin
      stk[i] = 21'h0a5a5 + 21'(i);
    end
  end
  // unread bus shows inverse of last byte, so stale data never matches
  assign rdata = rd ? mem[addr] : ~last;
  assign top   = stk[sp];
  always @(posedge clk) begin
    if (rd) last <= mem[addr];
    if (wr) mem[addr] <= wdata;
    if (push) begin
      sp <= sp + 3'h1;
      stk[sp + 3'h1] <= push_val;
    end else if (pop) sp <= sp - 3'h1;
  end
endmodule // xsie_far_model

// file: tb/xsie_exec_tb.sv
// self-checking bench for the extended instruction executor
// assumes the far-side model answers memory reads in the strobe cycle
`timescale 1ns/10ps
module xsie_exec_tb;
  import xsie_pkg::*;
  logic        clk, rst_n, ext_en, valid, q1, nop, ld, psh, pop;
  logic        rd, wr;
  logic [15:0] word;
  logic [20:0] pc_in, top, ld_val, psh_val, ld_v, psh_v;
  logic [7:0]  working_register, hl, ul, rdat, wdat, wr_d;
  logic [11:0] addr, ptr0, ptr1, ptr2, rd_a, wr_a;
  logic [11:0] p [3];
  logic [7:0]  em [4096];
  int          num_errors, samples_checked, nop_cnt, n_ld, n_psh, n_rd;
  int          n_pop;
  integer      seed, r;
  xsie_exec xsie_exec_i (.SYS_CLK(clk), .RESET_N(rst_n),
    .EXTENDED_SET_ENABLE_BIT(ext_en), .INSTR_WORD(word),
    .INSTR_VALID(valid), .Q1_STROBE(q1), .NOP_CYCLE(nop),
    .PC_IN(pc_in), .WORKING_REGISTER(working_register), .PC_HIGH_LATCH(hl),
    .PC_UPPER_LATCH(ul), .RETURN_STACK_TOP(top), .PC_LOAD(ld),
    .PC_LOAD_VAL(ld_val), .STACK_PUSH(psh), .STACK_PUSH_VAL(psh_val),
    .STACK_POP(pop), .DMEM_RD(rd), .DMEM_WR(wr), .DMEM_ADDR(addr),
    .DMEM_WDATA(wdat), .DMEM_RDATA(rdat), .PTR0(ptr0), .PTR1(ptr1),
    .PTR2(ptr2));
  xsie_far_model xsie_far_model_i (.clk(clk), .rd(rd), .wr(wr),
    .addr(addr), .wdata(wdat), .rdata(rdat), .push(psh), .pop(pop),
    .push_val(psh_val), .top(top));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // capture registered pulses at the edge that ends them
  always @(posedge clk) begin
    if (nop === 1'b1) nop_cnt++;
    if (pop === 1'b1) n_pop++;
    if (ld === 1'b1) begin
      n_ld++;
      ld_v = ld_val;
    end
    if (psh === 1'b1) begin
      n_psh++;
      psh_v = psh_val;
    end
    if (rd === 1'b1) begin
      n_rd++;
      rd_a = addr;
    end
    if (wr === 1'b1) begin
      wr_a = addr;
      wr_d = wdat;
    end
  end
  function automatic logic ind(input logic [11:0] a);
    return (a - IND_BASE0 < IND_SPAN) || (a - IND_BASE1 < IND_SPAN) ||
           (a - IND_BASE2 < IND_SPAN);
  endfunction
  task automatic chk(input string nm, input logic [20:0] ex,
                     input logic [20:0] got);
    samples_checked++;
    if (got !== ex) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // present a word at Q1, then run out the rest of the instruction
  task automatic issue(input logic [15:0] w, input int tail);
    int n;
    n = 0;
    while (q1 !== 1'b1 && n < 12) begin
      @(negedge clk);
      n++;
    end
    chk("q1", 21'(1), 21'(q1));
    word = w;
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    word = OP_NOP_WORD;
    repeat (tail) @(negedge clk);
  endtask
  task automatic clr();
    {nop_cnt, n_ld, n_psh, n_rd, n_pop} = '0;
  endtask
  task automatic add_ptr(input logic [1:0] f, input logic [5:0] k);
    clr();
    issue({OP_ADD_PTR_HI, f, k}, 8);
    if (ext_en) p[f == 2'h3 ? 2 : f] += {6'h0, k};
    chk("ptr0", 21'(p[0]), 21'(ptr0));
    chk("ptr1", 21'(p[1]), 21'(ptr1));
    chk("ptr2", 21'(p[2]), 21'(ptr2));
    chk("ld", 21'(f == 2'h3 && ext_en), 21'(n_ld));
    chk("pop", 21'(f == 2'h3 && ext_en), 21'(n_pop));
  endtask
  task automatic call_ret(input logic [5:0] k);
    logic [20:0] pc;
    pc = 21'($random(seed));
    pc_in = pc;
    {working_register, hl, ul} = 24'($random(seed));
    clr();
    issue(OP_CALL_WORKING_REGISTER, 8);
    chk("push", pc + PC_STEP, psh_v);
    chk("load", {ul[4:0], hl, working_register}, ld_v);
    chk("calls", 21'(1), 21'(n_ld));
    chk("nop", 21'(4), 21'(nop_cnt));
    add_ptr(2'h3, k);
    chk("ret", pc + PC_STEP, ld_v);
    chk("pops", 21'(1), 21'(n_pop));
    chk("nop2", 21'(4), 21'(nop_cnt));
  endtask
  task automatic move(input logic [6:0] z, input logic [11:0] d);
    logic [11:0] s;
    logic [7:0]  ex;
    s = p[2] + {5'h0, z};
    ex = ind(s) ? ZERO_BYTE : em[s];
    clr();
    issue({OP_MOVE_IDX_HI, z}, 0);
    issue({4'hf, d}, 8);
    em[d] = ex;
    chk("rd_cnt", ind(s) ? 21'(0) : 21'(1), 21'(n_rd));
    if (!ind(s)) chk("src", 21'(s), 21'(rd_a));
    chk("dst", 21'(d), 21'(wr_a));
    chk("data", 21'(ex), 21'(wr_d));
  endtask
  initial begin
    #300000;
    num_errors++;
    conclude();
  end
  initial begin
    {rst_n, valid, word, pc_in, working_register, hl, ul} = '0;
    ext_en = 1'b1;
    {num_errors, samples_checked} = '0;
    seed = 32'h9a3a;
    p = '{default: PTR_RST};
    for (int i = 0; i < 4096; i++) em[i] = 8'(i) ^ 8'(i >> 4);
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 150; i++) begin
      r = $random(seed);
      add_ptr(r[1:0] == 2'h3 ? 2'h0 : r[1:0], i == 0 ? 6'h3f : r[9:4]);
    end
    call_ret(6'h3f);
    call_ret(6'h00);
    for (int i = 0; i < 20; i++) begin
      r = $random(seed);
      // destinations kept clear of pc and stack-top bytes
      move(i == 0 ? 7'h7f : r[6:0], {1'b0, r[18:8]});
    end
    while (!(p[2] <= IND_BASE2 && IND_BASE2 - p[2] <= 12'h07f)) begin
      add_ptr(2'h2, 6'h3f);
    end
    move(7'(IND_BASE2 - p[2]), 12'h123);
    move(7'(IND_BASE2 - p[2] + 12'h005), 12'h124);
    ext_en = 1'b0;
    repeat (12) @(negedge clk);
    add_ptr(2'h0, 6'h05);
    clr();
    issue(OP_CALL_WORKING_REGISTER, 8);
    chk("no_push", 21'(0), 21'(n_psh));
    chk("no_load", 21'(0), 21'(n_ld));
    conclude();
  end
endmodule // xsie_exec_tb
